// File: verilog/embp_pkg.sv
// package for the external memory bus port: types, field layout, reset values, timing
package embp_pkg;

  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 16;
  localparam int          PORT_W          = 8;
  localparam int          LOW_LSB         = 0;
  localparam int          HIGH_LSB        = 8;
  localparam int          WAIT_W          = 4;
  localparam logic [3:0]  WAIT_RST        = 4'h0;
  localparam logic        GPIO_SEL_RST    = 1'b0;
  localparam logic [7:0]  PORT_DIR_RST    = 8'h00;
  localparam logic [7:0]  PORT_OUT_RST    = 8'h00;
  localparam logic [15:0] ADDR_RST        = 16'h0000;
  localparam logic [15:0] DATA_RST        = 16'h0000;
  localparam int          SETUP_CYC       = 1;
  localparam int          HOLD_CYC        = 1;

  typedef enum logic [2:0] {
    EMBP_IDLE   = 3'b000,
    EMBP_SETUP  = 3'b001,
    EMBP_STROBE = 3'b010,
    EMBP_HOLD    = 3'b011,
    EMBP_CAPTURE = 3'b100
  } embp_state_e;

  // request from the core side
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        prog_space;
    logic [15:0] addr;
    logic [15:0] wdata;
  } embp_req_s;

  // software configuration of one 8-bit pin group
  typedef struct packed {
    logic       gpio_sel;
    logic [7:0] dir;
    logic [7:0] out;
  } embp_port_cfg_s;

endpackage

// File: verilog/embp_pin_port.sv
// one 8-bit pin group: address bus function or general-purpose port
module embp_pin_port #(
  parameter int W = 8
) (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire embp_pkg::embp_port_cfg_s        cfg,
  input  wire logic [W-1:0]                    addr_bits,
  input  wire logic [W-1:0]                    pin_in,
  output logic      [W-1:0]                    pin_out,
  output logic      [W-1:0]                    pin_oe,
  output logic      [W-1:0]                    port_in
);

  typedef struct packed {
    logic [W-1:0] out;
    logic [W-1:0] oe;
    logic [W-1:0] sync1;
    logic [W-1:0] sync2;
  } embp_pp_s;

  embp_pp_s st_ff;
  embp_pp_s nxt_st;

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = pin_in;
    nxt_st.sync2 = st_ff.sync1;
    if (cfg.gpio_sel) begin
      // per-pin direction while owned by the port
      nxt_st.out = cfg.out;
      nxt_st.oe  = cfg.dir;
    end else begin
      // address bus drives every pin
      nxt_st.out = addr_bits;
      nxt_st.oe  = '1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '{out: '0, oe: '1, sync1: '0, sync2: '0}; // address role after reset
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_out = st_ff.out;
  assign pin_oe  = st_ff.oe;
  assign port_in = st_ff.sync2;

endmodule // embp_pin_port

// File: verilog/embp_bus_port.sv
// external memory bus port: address/data pins, space selects, read/write strobes

module embp_bus_port #(
  parameter int WAIT_W = embp_pkg::WAIT_W
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire embp_pkg::embp_req_s           req,
  input  wire logic [WAIT_W-1:0]             wait_states,
  input  wire embp_pkg::embp_port_cfg_s      low_cfg,
  input  wire embp_pkg::embp_port_cfg_s      high_cfg,
  output logic                               req_ready,
  output logic                               rd_done,
  output logic [15:0]                        rd_data,
  output logic [7:0]                         low_addr_port_bit_in,
  output logic [7:0]                         high_addr_port_bit_in,
  output logic [7:0]                         addr_lo_out,
  output logic [7:0]                         addr_lo_oe,
  input  wire logic [7:0]                    addr_lo_in,
  output logic [7:0]                         addr_hi_out,
  output logic [7:0]                         addr_hi_oe,
  input  wire logic [7:0]                    addr_hi_in,
  output logic [15:0]                        data_out,
  output logic                               data_oe,
  input  wire logic [15:0]                   data_in,
  output logic                               program_space_select_n,
  output logic                               data_space_select_n,
  output logic                               read_strobe_n,
  output logic                               write_strobe_n
);

  typedef struct packed {
    embp_pkg::embp_state_e state;
    logic [WAIT_W-1:0]     cnt;
    logic                  write;
    logic                  prog;
    logic [15:0]           addr;
    logic [15:0]           wdata;
    logic [15:0]           rdata;
    logic                  done;
    logic                  ready;
    logic                  prog_sel_n;
    logic                  data_sel_n;
    logic                  rd_n;
    logic                  wr_n;
    logic                  doe;
    logic [15:0]           dsync1;
    logic [15:0]           dsync2;
  } embp_bus_s;

  embp_bus_s st_ff;
  embp_bus_s nxt_st;

  // selects high and data lines released; idle and hold share this
  function automatic embp_bus_s release_bus(input embp_bus_s s);
    embp_bus_s r;
    r            = s;
    r.prog_sel_n = 1'b1;
    r.data_sel_n = 1'b1;
    r.doe        = 1'b0;
    return r;
  endfunction

  // a phase of n cycles loads n-1 and counts down to zero
  function automatic logic [WAIT_W-1:0] phase_load(input int cycles);
    return WAIT_W'(cycles - 1);
  endfunction

  // reset image: idle, bus released, every strobe and select high
  localparam embp_bus_s BUS_RST = '{
    state:      embp_pkg::EMBP_IDLE,
    cnt:        '0,
    write:      1'b0,
    prog:       1'b0,
    addr:       embp_pkg::ADDR_RST,
    wdata:      embp_pkg::DATA_RST,
    rdata:      embp_pkg::DATA_RST,
    done:       1'b0,
    ready:      1'b0,
    prog_sel_n: 1'b1,
    data_sel_n: 1'b1,
    rd_n:       1'b1,
    wr_n:       1'b1,
    doe:        1'b0,
    dsync1:     embp_pkg::DATA_RST,
    dsync2:     embp_pkg::DATA_RST
  };

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.done   = 1'b0;
    nxt_st.dsync1 = data_in;
    nxt_st.dsync2 = st_ff.dsync1;
    case (st_ff.state)
      embp_pkg::EMBP_IDLE: begin
        nxt_st       = release_bus(nxt_st); // bus released when idle
        nxt_st.ready = 1'b1;
        // taken only on an edge where ready already stands high
        if (req.valid && st_ff.ready) begin
          nxt_st.ready      = 1'b0;
          nxt_st.cnt        = phase_load(embp_pkg::SETUP_CYC);
          nxt_st.write      = req.write;
          nxt_st.prog       = req.prog_space;
          nxt_st.addr       = req.addr;
          nxt_st.wdata      = req.wdata;
          // exactly one space select per access
          nxt_st.prog_sel_n = !req.prog_space;
          nxt_st.data_sel_n = req.prog_space;
          nxt_st.doe        = req.write;
          nxt_st.state      = embp_pkg::EMBP_SETUP;
        end
      end

      embp_pkg::EMBP_SETUP: begin
        // address and select settle before the strobe falls
        if (st_ff.cnt == '0) begin
          nxt_st.cnt   = wait_states;
          nxt_st.rd_n  = st_ff.write;  // read strobe only on reads
          nxt_st.wr_n  = !st_ff.write; // write strobe only on writes
          nxt_st.state = embp_pkg::EMBP_STROBE;
        end else begin
          nxt_st.cnt = st_ff.cnt - 1'b1;
        end
      end

      embp_pkg::EMBP_STROBE: begin
        // wait states stretch the strobe low time
        if (st_ff.cnt == '0) begin
          nxt_st.rd_n  = 1'b1;
          nxt_st.wr_n  = 1'b1;
          nxt_st.cnt   = phase_load(embp_pkg::HOLD_CYC);
          nxt_st.state = embp_pkg::EMBP_HOLD;
        end else begin
          nxt_st.cnt = st_ff.cnt - 1'b1;
        end
      end

      embp_pkg::EMBP_HOLD: begin
        // address and select held past the strobe
        // write data stays driven until the release
        if (st_ff.cnt != '0) begin
          nxt_st.cnt = st_ff.cnt - 1'b1;
        end else begin
          nxt_st = release_bus(nxt_st);
          if (st_ff.write) begin
            nxt_st.ready = 1'b1;
            nxt_st.state = embp_pkg::EMBP_IDLE;
          end else begin
            nxt_st.state = embp_pkg::EMBP_CAPTURE;
          end
        end
      end

      embp_pkg::EMBP_CAPTURE: begin
        // synchroniser now shows the word present as the read strobe rose;
        // two cycles of latency, but even a zero wait state read is safe
        nxt_st.rdata = st_ff.dsync2;
        nxt_st.done  = 1'b1;
        nxt_st.ready = 1'b1;
        nxt_st.state = embp_pkg::EMBP_IDLE;
      end

      default: begin
        nxt_st.state = embp_pkg::EMBP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= BUS_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // pin groups: address role by default, port role on request
  embp_pin_port #(.W(embp_pkg::PORT_W)) u_low (
    .clk       (clk),
    .rst_n     (rst_n),
    .cfg       (low_cfg),
    .addr_bits (nxt_st.addr[embp_pkg::LOW_LSB +: embp_pkg::PORT_W]),
    .pin_in    (addr_lo_in),
    .pin_out   (addr_lo_out),
    .pin_oe    (addr_lo_oe),
    .port_in   (low_addr_port_bit_in)
  );

  embp_pin_port #(.W(embp_pkg::PORT_W)) u_high (
    .clk       (clk),
    .rst_n     (rst_n),
    .cfg       (high_cfg),
    .addr_bits (nxt_st.addr[embp_pkg::HIGH_LSB +: embp_pkg::PORT_W]),
    .pin_in    (addr_hi_in),
    .pin_out   (addr_hi_out),
    .pin_oe    (addr_hi_oe),
    .port_in   (high_addr_port_bit_in)
  );

  // every pin and status output comes straight from a flip-flop
  assign req_ready              = st_ff.ready;
  assign rd_done                = st_ff.done;
  assign rd_data                = st_ff.rdata;
  assign data_out               = st_ff.wdata;
  assign data_oe                = st_ff.doe;
  assign program_space_select_n = st_ff.prog_sel_n;
  assign data_space_select_n    = st_ff.data_sel_n;
  assign read_strobe_n          = st_ff.rd_n;
  assign write_strobe_n         = st_ff.wr_n;

endmodule // embp_bus_port

// File: verif/embp_bus_port_props.sv
// checker for the external memory bus port pins
module embp_bus_port_props (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire embp_pkg::embp_req_s      req,
  input wire embp_pkg::embp_port_cfg_s low_cfg,
  input wire embp_pkg::embp_port_cfg_s high_cfg,
  input wire logic                     req_ready,
  input wire logic                     rd_done,
  input wire logic [7:0]               addr_lo_out,
  input wire logic [7:0]               addr_hi_out,
  input wire logic                     data_oe,
  input wire logic                     program_space_select_n,
  input wire logic                     data_space_select_n,
  input wire logic                     read_strobe_n,
  input wire logic                     write_strobe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_taken;
    req.valid && req_ready;
  endsequence
  sequence s_rd_taken;
    req.valid && req_ready && !req.write;
  endsequence
  a_sel_excl: assert property (program_space_select_n || data_space_select_n)
    else $error("both selects low");
  a_strb_excl: assert property (read_strobe_n || write_strobe_n)
    else $error("both strobes low");
  a_idle_release: assert property (
    program_space_select_n && data_space_select_n |-> !data_oe) else $error("bus driven idle");
  a_rd_release: assert property (!read_strobe_n |-> !data_oe)
    else $error("bus driven in read");
  a_wr_drive: assert property (!write_strobe_n |-> data_oe)
    else $error("bus not driven in write");
  a_take_select: assert property (s_taken |-> ##2
    program_space_select_n == !$past(req.prog_space, 2)
    && data_space_select_n == $past(req.prog_space, 2)) else $error("wrong select");
  a_addr_low: assert property (s_taken ##0 !low_cfg.gpio_sel |-> ##2
    addr_lo_out == $past(req.addr[7:0], 2)) else $error("wrong low address");
  a_addr_high: assert property (s_taken ##0 !high_cfg.gpio_sel |-> ##2
    addr_hi_out == $past(req.addr[15:8], 2)) else $error("wrong high address");
  a_read_done: assert property (s_rd_taken |-> ##[5:20] rd_done)
    else $error("read never completed");
endmodule // embp_bus_port_props
bind embp_bus_port embp_bus_port_props u_props (.clk, .rst_n, .req, .low_cfg, .high_cfg,
  .req_ready, .rd_done, .addr_lo_out, .addr_hi_out, .data_oe, .program_space_select_n,
  .data_space_select_n, .read_strobe_n, .write_strobe_n);

// File: verif/embp_sram_model.sv
// behavioural external static memory on the far side of the bus port
module embp_sram_model (
  input  wire logic [15:0] addr,
  input  wire logic        prog_sel_n,
  input  wire logic        data_sel_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [15:0] bus,
  output logic      [15:0] q,
  output logic             q_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [0:511];
  // address and selects trusted only at the strobe, never between accesses
  always @(posedge wr_n) begin
    if (prog_sel_n != data_sel_n) begin
      mem[{prog_sel_n, addr[7:0]}] = bus;
    end
  end
  assign q_oe = !rd_n && (prog_sel_n != data_sel_n);
  assign q    = mem[{prog_sel_n, addr[7:0]}];
endmodule // embp_sram_model

// File: verif/embp_bus_port_bench.sv
// self-checking bench for the external memory bus port
module embp_bus_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                     clk;
  logic                     rst_n;
  embp_pkg::embp_req_s      req;
  logic [3:0]               ws;
  embp_pkg::embp_port_cfg_s low_cfg;
  embp_pkg::embp_port_cfg_s high_cfg;
  logic                     req_ready;
  logic                     rd_done;
  logic [15:0]              rd_data;
  logic [7:0]               lo_port;
  logic [7:0]               hi_port;
  logic [7:0]               lo_out;
  logic [7:0]               lo_oe;
  logic [7:0]               hi_out;
  logic [7:0]               hi_oe;
  logic [7:0]               lo_ext;
  logic [15:0]              d_out;
  logic                     d_oe;
  logic [15:0]              m_q;
  logic                     m_oe;
  logic                     psel_n;
  logic                     dsel_n;
  logic                     rd_n;
  logic                     wr_n;
  int                       fails;
  int                       total_checks;
  wire  [7:0]               lo_pin = (lo_oe & lo_out) | (~lo_oe & lo_ext);
  // undriven pins float up through the pad pull-ups
  wire  [7:0]               hi_pin = (hi_oe & hi_out) | ~hi_oe;
  wire  [15:0]              d_bus  = d_oe ? d_out : (m_oe ? m_q : 16'hFFFF);
  embp_bus_port dut (.clk, .rst_n, .req, .wait_states(ws), .low_cfg, .high_cfg, .req_ready,
    .rd_done, .rd_data, .low_addr_port_bit_in(lo_port), .high_addr_port_bit_in(hi_port),
    .addr_lo_out(lo_out), .addr_lo_oe(lo_oe), .addr_lo_in(lo_pin), .addr_hi_out(hi_out),
    .addr_hi_oe(hi_oe), .addr_hi_in(hi_pin), .data_out(d_out), .data_oe(d_oe), .data_in(d_bus),
    .program_space_select_n(psel_n), .data_space_select_n(dsel_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n));
  embp_sram_model mem_side (.addr({hi_pin, lo_pin}), .prog_sel_n(psel_n), .data_sel_n(dsel_n),
    .rd_n, .wr_n, .bus(d_bus), .q(m_q), .q_oe(m_oe));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_for(input logic which);
    int n;
    n = 0;
    while ((which ? rd_done : req_ready) !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 40) begin
      fails++;
      $display("mismatch at %0t: handshake timed out", $time);
    end
  endtask
  // request held until the edge that sees ready high, dropped just after it
  task automatic access(input logic wr, input logic prog, input logic [15:0] a,
                        input logic [15:0] d, output logic [15:0] q);
    wait_for(1'b0);
    req = '{1'b1, wr, prog, a, d};
    @(posedge clk);
    #1;
    req.valid = 1'b0;
    if (!wr) wait_for(1'b1);
    q = rd_data;
    wait_for(1'b0);
  endtask
  task automatic t_rw;
    logic [15:0] q;
    // zero, one and three wait states
    for (int w = 0; w <= 3; w += w + 1) begin
      ws = w[3:0];
      access(1'b1, 1'b1, 16'h12F0, 16'hA50F ^ w[15:0], q);
      access(1'b1, 1'b0, 16'h12F0, 16'h5AF0 ^ w[15:0], q);
      access(1'b0, 1'b1, 16'h12F0, 16'h0000, q);
      chk(q, 16'hA50F ^ w[15:0]);
      access(1'b0, 1'b0, 16'h12F0, 16'h0000, q);
      chk(q, 16'h5AF0 ^ w[15:0]);
    end
  endtask
  task automatic t_gpio;
    logic [15:0] q;
    low_cfg = '{1'b1, 8'hF0, 8'hA5};
    lo_ext = 8'h3C;
    repeat (4) @(posedge clk);
    #1;
    chk({lo_port, lo_pin}, 16'hACAC);
    access(1'b1, 1'b0, 16'h7E11, 16'h1357, q);
    access(1'b0, 1'b0, 16'h7E11, 16'h0000, q);
    chk(q, 16'h1357);
    chk({hi_oe, hi_out}, 16'hFF7E);
    chk({hi_port, hi_pin}, 16'h7E7E);
    chk({8'h00, lo_oe}, 16'h00F0);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    fails = 0;
    total_checks = 0;
    rst_n = 1'b0;
    req = '0;
    ws = 4'h1;
    low_cfg = '0;
    high_cfg = '0;
    lo_ext = 8'hFF;
    repeat (3) @(posedge clk);
    #1;
    chk({lo_oe, hi_oe}, 16'hFFFF);
    chk({11'h000, d_oe, psel_n, dsel_n, rd_n, wr_n}, 16'h000F);
    rst_n = 1'b1;
    t_rw;
    t_gpio;
    report_and_stop;
  end
  initial begin
    #50000;
    fails++;
    report_and_stop;
  end
endmodule // embp_bus_port_bench
